// ---- common/doc_cfg.svh ----
`ifndef DOC_CFG_SVH
`define DOC_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define DOC_CLK_HZ 100000000
`define DOC_TICK_S 1
`define DOC_TICK_CYCLES (`DOC_CLK_HZ * `DOC_TICK_S)
`define DOC_TIME_W 16
`define DOC_STYLE_W 3
// ----------------------------------------
// style encodings
// ----------------------------------------
`define DOC_STYLE_PASS 3'h0
`define DOC_STYLE_DELAY 3'h1
`define DOC_STYLE_EXTEND 3'h2
`define DOC_STYLE_PULSE 3'h3
`define DOC_STYLE_RETRIG 3'h4
`endif

// ---- common/doc_pkg.sv ----
package doc_pkg;
    typedef enum logic [2:0] {
        DOC_PASS = 3'h0,
        DOC_DELAY = 3'h1,
        DOC_EXTEND = 3'h2,
        DOC_PULSE = 3'h3,
        DOC_RETRIG = 3'h4
    } doc_style_t;
endpackage

// ---- rtl/doc_tick_gen.sv ----
`timescale 1ns/1ps
`include "doc_cfg.svh"
// ----------------------------------------
// one-second tick generator
// ----------------------------------------
module doc_tick_gen #(
    parameter int TICK_CYCLES = `DOC_TICK_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic restart_in,
    output logic tick_out
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_r;
    wire last_w = (cnt_r == 32'(TICK_CYCLES - 1));

    // restart re-phases the second so each interval starts whole
    assign cnt_nxt = (restart_in || last_w) ? 32'h0 : cnt_r + 32'h1;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else if (clk_en_in) begin
            cnt_r <= cnt_nxt;
            // look ahead one cycle so the registered tick lands exactly TICK_CYCLES after a restart
            tick_r <= (cnt_nxt == 32'(TICK_CYCLES - 1));
        end
    end

    assign tick_out = tick_r;
endmodule

// ---- rtl/doc_conditioner.sv ----
`timescale 1ns/1ps
`include "doc_cfg.svh"
module doc_conditioner #(
    parameter int TICK_CYCLES = `DOC_TICK_CYCLES,
    parameter int TIME_W = `DOC_TIME_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic result_in,
    input wire logic [2:0] style_in,
    input wire logic [TIME_W-1:0] cond_time_in,
    output logic conditioned_output_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    doc_pkg::doc_style_t style_r;
    logic res_d_r;
    logic out_r;
    logic out_nxt;
    logic run_r;
    logic run_nxt;
    logic [TIME_W-1:0] secs_r;
    logic [TIME_W-1:0] secs_nxt;
    logic tick_w;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire style_chg_w = (style_in != 3'(style_r));
    wire rise_w = result_in && !res_d_r;
    wire fall_w = !result_in && res_d_r;
    wire done_w = run_r && tick_w && (secs_r + TIME_W'(1) >= cond_time_in);
    wire zero_t_w = (cond_time_in == '0);
    // timer restarts on the edges that open an interval
    wire restart_w = (style_r == doc_pkg::DOC_DELAY && rise_w) ||
                     (style_r == doc_pkg::DOC_EXTEND && fall_w) ||
                     (style_r == doc_pkg::DOC_PULSE && rise_w && !run_r) ||
                     (style_r == doc_pkg::DOC_RETRIG && rise_w);

    doc_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .restart_in(restart_w || style_chg_w),
        .tick_out(tick_w)
    );

    // ----------------------------------------
    // style behaviour
    // ----------------------------------------
    // a zero interval degenerates delay and extend to pass-through; pulse and retrigger keep the output low
    always_comb begin
        out_nxt = out_r;
        run_nxt = run_r;
        secs_nxt = (run_r && tick_w) ? secs_r + TIME_W'(1) : secs_r;
        case (style_r)
            doc_pkg::DOC_PASS: begin
                out_nxt = result_in;
                run_nxt = 1'b0;
            end
            doc_pkg::DOC_DELAY: begin
                if (!result_in) begin
                    out_nxt = 1'b0;
                    run_nxt = 1'b0;
                end else if (rise_w) begin
                    out_nxt = zero_t_w;
                    run_nxt = !zero_t_w;
                    secs_nxt = '0;
                end else if (done_w) begin
                    out_nxt = 1'b1;
                    run_nxt = 1'b0;
                end
            end
            doc_pkg::DOC_EXTEND: begin
                if (result_in) begin
                    out_nxt = 1'b1;
                    run_nxt = 1'b0;
                end else if (fall_w) begin
                    out_nxt = !zero_t_w;
                    run_nxt = !zero_t_w;
                    secs_nxt = '0;
                end else if (done_w) begin
                    out_nxt = 1'b0;
                    run_nxt = 1'b0;
                end
            end
            doc_pkg::DOC_PULSE: begin
                if (rise_w && !run_r) begin
                    out_nxt = !zero_t_w;
                    run_nxt = !zero_t_w;
                    secs_nxt = '0;
                end else if (done_w) begin
                    out_nxt = 1'b0;
                    run_nxt = 1'b0;
                end
            end
            doc_pkg::DOC_RETRIG: begin
                if (rise_w) begin
                    out_nxt = !zero_t_w;
                    run_nxt = !zero_t_w;
                    secs_nxt = '0;
                end else if (done_w) begin
                    out_nxt = 1'b0;
                    run_nxt = 1'b0;
                end
            end
            default: begin
                out_nxt = 1'b0;
                run_nxt = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // style change flushes timers; edge history kept so new style sees fresh edges
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            style_r <= doc_pkg::DOC_PASS;
            res_d_r <= 1'b0;
            out_r <= 1'b0;
            run_r <= 1'b0;
            secs_r <= '0;
        end else if (clk_en_in) begin
            res_d_r <= result_in;
            if (style_chg_w) begin
                style_r <= doc_pkg::doc_style_t'(style_in);
                out_r <= 1'b0;
                run_r <= 1'b0;
                secs_r <= '0;
            end else begin
                out_r <= out_nxt;
                run_r <= run_nxt;
                secs_r <= secs_nxt;
            end
        end
    end

    assign conditioned_output_out = out_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_pass_follow;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rst_n_in && clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_PASS) |=> (out_r == $past(result_in));
    endproperty
    a_pass_follow: assert property (p_pass_follow) else $error("pass style output mismatch");

    property p_delay_low_on_fall;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && style_r == doc_pkg::DOC_DELAY && !result_in) |=> !out_r;
    endproperty
    a_delay_low_on_fall: assert property (p_delay_low_on_fall) else $error("delay output not low");

    property p_delay_no_early;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && style_r == doc_pkg::DOC_DELAY && rise_w && !zero_t_w) |=> !out_r;
    endproperty
    a_delay_no_early: assert property (p_delay_no_early) else $error("delay output rose early");

    property p_extend_rise;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_EXTEND && result_in) |=> out_r;
    endproperty
    a_extend_rise: assert property (p_extend_rise) else $error("extend output not high");

    property p_extend_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_EXTEND && fall_w && !zero_t_w) |=> (out_r && run_r);
    endproperty
    a_extend_hold: assert property (p_extend_hold) else $error("extend did not stretch");

    property p_pulse_ignore;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_PULSE && run_r && rise_w && !done_w)
            |=> (secs_r == $past(secs_r) + TIME_W'($past(tick_w)));
    endproperty
    a_pulse_ignore: assert property (p_pulse_ignore) else $error("pulse retriggered");

    property p_pulse_start;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_PULSE && rise_w && !run_r && !zero_t_w)
            |=> (out_r && secs_r == '0);
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

    property p_retrig_restart;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_RETRIG && rise_w && !zero_t_w)
            |=> (out_r && run_r && secs_r == '0);
    endproperty
    a_retrig_restart: assert property (p_retrig_restart) else $error("retrigger did not restart");

    property p_style_clear;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && style_chg_w) |=> (!out_r && !run_r);
    endproperty
    a_style_clear: assert property (p_style_clear) else $error("style change did not clear");

    property p_delay_done;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_DELAY && result_in && !rise_w && done_w) |=> out_r;
    endproperty
    a_delay_done: assert property (p_delay_done) else $error("delay output did not rise");

    property p_extend_drop;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_EXTEND && !result_in && !fall_w && done_w) |=> !out_r;
    endproperty
    a_extend_drop: assert property (p_extend_drop) else $error("extend output did not drop");

    property p_retrig_end;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (clk_en_in && !style_chg_w && style_r == doc_pkg::DOC_RETRIG && done_w && !rise_w) |=> !out_r;
    endproperty
    a_retrig_end: assert property (p_retrig_end) else $error("retrigger output did not end");
endmodule

// ---- sim/doc_cmp_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// upstream comparator model
// ----------------------------------------
module doc_cmp_model (
    input wire logic [7:0] value_a_in,
    input wire logic [7:0] value_b_in,
    output logic result_out
);
    // greater-than compare; equal values give 0, so a tie never counts as a hit
    assign result_out = (value_a_in > value_b_in);
endmodule

// ---- sim/doc_conditioner_test.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// bench top
// ----------------------------------------
module doc_conditioner_test;
    // short tick keeps the run small; interval is SECS * TICKS cycles
    localparam int TICKS = 4;
    typedef struct packed {doc_pkg::doc_style_t style; int h1; int gap; int h2; int probe; logic exp;} doc_row_t;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic [2:0] style_in = 3'h7;
    logic [15:0] cond_time_in = 16'h0002;
    logic [7:0] value_a = 8'h80;
    logic [7:0] value_b = 8'h80;
    logic result;
    logic cond_out;
    int err_total = 0;
    int total_checks = 0;
    // style, high, gap, second high, probe cycle, expected output
    // probe pairs straddle the cycle at which each interval must end
    doc_row_t rows[26] = '{
        '{doc_pkg::DOC_PASS, 5, 0, 0, 3, 1'b1},
        '{doc_pkg::DOC_PASS, 5, 0, 0, 8, 1'b0},
        '{doc_pkg::DOC_DELAY, 20, 0, 0, 7, 1'b0},
        '{doc_pkg::DOC_DELAY, 20, 0, 0, 8, 1'b0},
        '{doc_pkg::DOC_DELAY, 20, 0, 0, 9, 1'b1},
        '{doc_pkg::DOC_DELAY, 20, 0, 0, 12, 1'b1},
        '{doc_pkg::DOC_DELAY, 20, 0, 0, 23, 1'b0},
        '{doc_pkg::DOC_DELAY, 6, 0, 0, 12, 1'b0},
        '{doc_pkg::DOC_EXTEND, 3, 0, 0, 2, 1'b1},
        '{doc_pkg::DOC_EXTEND, 3, 0, 0, 10, 1'b1},
        '{doc_pkg::DOC_EXTEND, 3, 0, 0, 11, 1'b1},
        '{doc_pkg::DOC_EXTEND, 3, 0, 0, 12, 1'b0},
        '{doc_pkg::DOC_EXTEND, 3, 0, 0, 15, 1'b0},
        '{doc_pkg::DOC_PULSE, 3, 2, 3, 8, 1'b1},
        '{doc_pkg::DOC_PULSE, 3, 2, 3, 12, 1'b0},
        '{doc_pkg::DOC_PULSE, 20, 0, 0, 8, 1'b1},
        '{doc_pkg::DOC_PULSE, 20, 0, 0, 9, 1'b0},
        '{doc_pkg::DOC_PULSE, 20, 0, 0, 12, 1'b0},
        '{doc_pkg::DOC_RETRIG, 3, 2, 3, 5, 1'b1},
        '{doc_pkg::DOC_RETRIG, 3, 2, 3, 12, 1'b1},
        '{doc_pkg::DOC_RETRIG, 3, 2, 3, 13, 1'b1},
        '{doc_pkg::DOC_RETRIG, 3, 2, 3, 14, 1'b0},
        '{doc_pkg::DOC_RETRIG, 3, 2, 3, 17, 1'b0},
        '{doc_pkg::DOC_RETRIG, 20, 0, 0, 8, 1'b1},
        '{doc_pkg::DOC_RETRIG, 20, 0, 0, 9, 1'b0},
        '{doc_pkg::DOC_RETRIG, 20, 0, 0, 12, 1'b0}
    };

    // ----------------------------------------
    // clock, partner and design
    // ----------------------------------------
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    doc_cmp_model cmp (.value_a_in(value_a), .value_b_in(value_b), .result_out(result));
    doc_conditioner #(.TICK_CYCLES(TICKS), .TIME_W(16)) dut (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .result_in(result),
        .style_in(style_in),
        .cond_time_in(cond_time_in),
        .conditioned_output_out(cond_out)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic exp, input logic seen);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // parks in an unused style first so every row starts from cleared timers
    task automatic run_row(input doc_row_t r);
        int k;
        @(posedge ref_clk_in);
        style_in <= 3'h7;
        value_a <= 8'h80;
        repeat (3) @(posedge ref_clk_in);
        style_in <= r.style;
        repeat (3) @(posedge ref_clk_in);
        for (k = 0; k < r.probe; k++) begin
            value_a <= ((k < r.h1) || (k >= r.h1 + r.gap && k < r.h1 + r.gap + r.h2)) ? 8'hC0 : 8'h80;
            @(posedge ref_clk_in);
        end
        #1;
        check($sformatf("output style %0d probe %0d", r.style, r.probe), r.exp, cond_out);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        #1 check("output at reset release", 1'b0, cond_out);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        $display("table test done");
        // reset in mid-pulse must drop the output at once
        run_row('{doc_pkg::DOC_PULSE, 20, 0, 0, 4, 1'b1});
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        @(posedge ref_clk_in);
        #1 check("output after reset", 1'b0, cond_out);
        @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        value_a <= 8'h80;
        $display("reset test done");
        // style change while the extension still runs
        run_row('{doc_pkg::DOC_EXTEND, 3, 0, 0, 8, 1'b1});
        @(posedge ref_clk_in);
        style_in <= doc_pkg::DOC_RETRIG;
        repeat (2) @(posedge ref_clk_in);
        #1 check("output after style change", 1'b0, cond_out);
        $display("style change test done");
        // frozen enable stops the timebase, so the pulse outlives the interval
        run_row('{doc_pkg::DOC_PULSE, 3, 0, 0, 4, 1'b1});
        @(posedge ref_clk_in);
        clk_en_in <= 1'b0;
        repeat (30) @(posedge ref_clk_in);
        #1 check("output while frozen", 1'b1, cond_out);
        @(posedge ref_clk_in);
        clk_en_in <= 1'b1;
        repeat (12) @(posedge ref_clk_in);
        #1 check("output after thaw", 1'b0, cond_out);
        $display("enable test done");
        // a one-second interval must end the pulse after a single tick
        @(posedge ref_clk_in);
        cond_time_in <= 16'h0001;
        run_row('{doc_pkg::DOC_PULSE, 20, 0, 0, 4, 1'b1});
        run_row('{doc_pkg::DOC_PULSE, 20, 0, 0, 5, 1'b0});
        $display("interval test done");
        close_out();
    end

    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule
